// ### cdrcr_pkg.sv
// Purpose: Constants for the CDR control register bank.
// Assumes: Byte-wide registers at byte addresses on the management port.
// Notes: Reset values not printed are chosen plain values.
package cdrcr_pkg;
  localparam logic [7:0] ADDR_RESET_LOCK = 8'h09;
  localparam logic [7:0] ADDR_REF_CLOCK = 8'h0A;
  localparam logic [7:0] ADDR_REF_LOCK = 8'h0F;
  localparam logic [7:0] ADDR_LOOP_EDGE = 8'h10;
  localparam logic [7:0] ADDR_SLICE_SLEW = 8'h13;
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_ACQ_TRIG = 6;
  localparam int BIT_BYPASS = 5;
  localparam int BIT_LOL_MODE = 4;
  localparam int BIT_SIGNAL_LOSS_POWERDOWN = 3;
  localparam int BIT_LOS_POL = 2;
  localparam int BIT_REF_PDN = 2;
  localparam int BIT_LOL_SRC = 6;
  localparam int BIT_STATIC_CLR = 2;
  localparam int BIT_STATIC_LOL = 2;
  localparam logic [7:0] RST_RESET_LOCK = 8'h00;
  localparam logic [7:0] RST_REF_CLOCK = 8'h05;
  localparam logic [7:0] RST_REF_LOCK = 8'h00;
  localparam logic [7:0] RST_LOOP_EDGE = 8'h04;
  localparam logic [7:0] RST_SLICE_SLEW = 8'h00;
  localparam logic [7:0] MASK_RESET_LOCK = 8'hFC;
  localparam logic [7:0] MASK_REF_CLOCK = 8'h05;
  localparam logic [7:0] MASK_REF_LOCK = 8'h7F;
  localparam logic [7:0] MASK_LOOP_EDGE = 8'h1F;
  localparam logic [7:0] MASK_SLICE_SLEW = 8'h07;
  localparam logic [3:0] RATIO_MAX = 4'hA;
endpackage

// ### cdrcr_pulse.sv
// Purpose: Detects a one-then-zero write sequence on one control bit.
// Assumes: Bit value is sampled on each register write strobe.
// Notes: Pulse lasts one cycle, the cycle after the write that clears the bit.
`timescale 1ns/1ps
`default_nettype none
module cdrcr_pulse (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic i_bit,
  output logic o_pulse
);
  logic armed;
  logic next_armed;
  logic pulse;
  logic next_pulse;
  always_comb begin
    next_armed = armed;
    next_pulse = 1'b0;
    if (i_wr) begin
      next_armed = i_bit;
      next_pulse = armed && !i_bit;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      armed <= 1'b0;
      pulse <= 1'b0;
    end else begin
      armed <= next_armed;
      pulse <= next_pulse;
    end
  end
  assign o_pulse = pulse;
endmodule
`default_nettype wire

// ### cdrcr_bank.sv
// Purpose: Control register bank of a clock and data recovery receiver.
// Assumes: A management port decoder presents byte writes and reads.
// Notes: Outputs steer the analog loop; lock loss arrives as a level.
// Summary of operation
// R1 - Writing one then zero to the top reset bit fully resets the device; the bank keeps sticky lock loss.
// R2 - Writing one then zero to the acquisition bit starts frequency acquisition.
// R3 - Signal-loss power-down bit one disables signal-loss detection.
// R4 - Signal-loss pin is active high for polarity zero, active low for one.
// R5 - Reference clock stays off until the host writes its power-down bit zero.
// R6 - Lock-loss source bit picks reference clock or data comparison.
// R7 - Two-bit band field selects one of four doubling reference bands.
// R8 - Four-bit ratio field encodes two to the code minus one.
// R9 - Edge field chooses both, rising only or falling only edges.
// R10 - Bandwidth field scales the loop bandwidth by value over four, default four.
// R11 - Adaptive slice bit one enables automatic slice threshold adjust.
// R12 - Two-bit slew field sets the delay-locked loop bandwidth.
// R13 - Bypass bit one routes data around the recovery loop.
// R14 - Lock-loss mode zero reports live, one reports sticky.
// R15 - Host writes reserved bits zero, reference register bit zero as one.
// R16 - Sticky lock loss holds until the host writes the clear bit.
`timescale 1ns/1ps
`default_nettype none
module cdrcr_bank (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_lock_loss_ref,
  input wire logic i_lock_loss_data,
  input wire logic i_signal_loss_raw,
  output logic o_device_reset,
  output logic o_freq_acquire_trigger,
  output logic o_cdr_bypass,
  output logic o_signal_loss_enable,
  output logic o_signal_loss_flag,
  output logic o_ref_clock_enable,
  output logic o_lock_loss_flag,
  output logic [1:0] o_ref_freq_band,
  output logic [3:0] o_rate_to_ref_divide,
  output logic o_edge_rise,
  output logic o_edge_fall,
  output logic [2:0] o_transfer_bw_scale,
  output logic o_adaptive_slice,
  output logic [1:0] o_dll_slew
);
  logic [7:0] reset_lock_control;
  logic [7:0] ref_clock_control;
  logic [7:0] reference_lock_setup;
  logic [7:0] loop_edge_bandwidth;
  logic [7:0] slice_slew_control;
  logic sticky_lol;
  logic [7:0] next_reset_lock_control;
  logic [7:0] next_ref_clock_control;
  logic [7:0] next_reference_lock_setup;
  logic [7:0] next_loop_edge_bandwidth;
  logic [7:0] next_slice_slew_control;
  logic next_sticky_lol;
  logic lol_live;
  logic los_out;
  logic lol_out;
  logic [7:0] next_rdata;
  logic soft_rst_pulse;
  logic acq_pulse;
  logic bank_rst;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  cdrcr_pulse u_reset_seq (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(i_wr && hit(i_addr, cdrcr_pkg::ADDR_RESET_LOCK)),
    .i_bit(i_wdata[cdrcr_pkg::BIT_SOFT_RESET]),
    .o_pulse(soft_rst_pulse)
  );
  cdrcr_pulse u_acq_seq (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(i_wr && hit(i_addr, cdrcr_pkg::ADDR_RESET_LOCK)),
    .i_bit(i_wdata[cdrcr_pkg::BIT_ACQ_TRIG]),
    .o_pulse(acq_pulse)
  );

  // The soft reset pulse returns the five control registers to their reset values; sticky lock loss is kept. [R1]
  assign bank_rst = i_sys_rst || soft_rst_pulse;

  always_comb begin
    next_reset_lock_control = reset_lock_control;
    next_ref_clock_control = ref_clock_control;
    next_reference_lock_setup = reference_lock_setup;
    next_loop_edge_bandwidth = loop_edge_bandwidth;
    next_slice_slew_control = slice_slew_control;
    if (i_wr) begin
      // Reserved bits are kept at their fixed values regardless of the write. [R15]
      if (hit(i_addr, cdrcr_pkg::ADDR_RESET_LOCK)) begin
        next_reset_lock_control = i_wdata & cdrcr_pkg::MASK_RESET_LOCK;
      end
      if (hit(i_addr, cdrcr_pkg::ADDR_REF_CLOCK)) begin
        next_ref_clock_control = (i_wdata & cdrcr_pkg::MASK_REF_CLOCK) | 8'h01;
      end
      if (hit(i_addr, cdrcr_pkg::ADDR_REF_LOCK)) begin
        next_reference_lock_setup = i_wdata & cdrcr_pkg::MASK_REF_LOCK;
      end
      if (hit(i_addr, cdrcr_pkg::ADDR_LOOP_EDGE)) begin
        next_loop_edge_bandwidth = i_wdata & cdrcr_pkg::MASK_LOOP_EDGE;
      end
      if (hit(i_addr, cdrcr_pkg::ADDR_SLICE_SLEW)) begin
        next_slice_slew_control = i_wdata & cdrcr_pkg::MASK_SLICE_SLEW;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (bank_rst) begin
      reset_lock_control <= cdrcr_pkg::RST_RESET_LOCK;
      ref_clock_control <= cdrcr_pkg::RST_REF_CLOCK;
      reference_lock_setup <= cdrcr_pkg::RST_REF_LOCK;
      loop_edge_bandwidth <= cdrcr_pkg::RST_LOOP_EDGE;
      slice_slew_control <= cdrcr_pkg::RST_SLICE_SLEW;
    end else begin
      reset_lock_control <= next_reset_lock_control;
      ref_clock_control <= next_ref_clock_control;
      reference_lock_setup <= next_reference_lock_setup;
      loop_edge_bandwidth <= next_loop_edge_bandwidth;
      slice_slew_control <= next_slice_slew_control;
    end
  end

  // Lock loss compares against the reference or the data as selected. [R6]
  assign lol_live = reference_lock_setup[cdrcr_pkg::BIT_LOL_SRC] ? i_lock_loss_data : i_lock_loss_ref;

  always_comb begin
    next_sticky_lol = sticky_lol;
    if (i_wr && hit(i_addr, cdrcr_pkg::ADDR_MAIN_CTRL) && i_wdata[cdrcr_pkg::BIT_STATIC_CLR]) begin
      next_sticky_lol = 1'b0;
    end
    // A new event wins over a clear in the same cycle. [R16]
    if (lol_live) begin
      next_sticky_lol = 1'b1;
    end
  end

  // Detection off forces the signal-loss result inactive. [R3]
  // Pin polarity follows the polarity bit. [R4]
  assign los_out = (i_signal_loss_raw && !reset_lock_control[cdrcr_pkg::BIT_SIGNAL_LOSS_POWERDOWN])
    ^ reset_lock_control[cdrcr_pkg::BIT_LOS_POL];
  // Live or sticky reporting as chosen by the mode bit. [R14]
  assign lol_out = reset_lock_control[cdrcr_pkg::BIT_LOL_MODE] ? sticky_lol : lol_live;

  always_comb begin
    next_rdata = 8'h00;
    unique case (i_addr)
      cdrcr_pkg::ADDR_RESET_LOCK: next_rdata = reset_lock_control;
      cdrcr_pkg::ADDR_REF_CLOCK: next_rdata = ref_clock_control;
      cdrcr_pkg::ADDR_REF_LOCK: next_rdata = reference_lock_setup;
      cdrcr_pkg::ADDR_LOOP_EDGE: next_rdata = loop_edge_bandwidth;
      cdrcr_pkg::ADDR_SLICE_SLEW: next_rdata = slice_slew_control;
      cdrcr_pkg::ADDR_STATUS: next_rdata = {5'h00, sticky_lol, 2'h0};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sticky_lol <= 1'b0;
      o_rdata <= 8'h00;
      o_signal_loss_flag <= 1'b0;
      o_lock_loss_flag <= 1'b0;
    end else begin
      sticky_lol <= next_sticky_lol;
      o_rdata <= next_rdata;
      o_signal_loss_flag <= los_out;
      o_lock_loss_flag <= lol_out;
    end
  end

  assign o_device_reset = soft_rst_pulse; // [R1]
  assign o_freq_acquire_trigger = acq_pulse; // [R2]
  assign o_cdr_bypass = reset_lock_control[cdrcr_pkg::BIT_BYPASS]; // [R13]
  assign o_signal_loss_enable = !reset_lock_control[cdrcr_pkg::BIT_SIGNAL_LOSS_POWERDOWN]; // [R3]
  assign o_ref_clock_enable = !ref_clock_control[cdrcr_pkg::BIT_REF_PDN]; // [R5]
  assign o_ref_freq_band = reference_lock_setup[5:4]; // [R7]
  assign o_rate_to_ref_divide = reference_lock_setup[3:0]; // [R8]
  assign o_edge_rise = (loop_edge_bandwidth[4:3] != 2'b10); // [R9]
  assign o_edge_fall = (loop_edge_bandwidth[4:3] != 2'b01); // [R9]
  assign o_transfer_bw_scale = loop_edge_bandwidth[2:0]; // [R10]
  assign o_adaptive_slice = slice_slew_control[2]; // [R11]
  assign o_dll_slew = slice_slew_control[1:0]; // [R12]

  a_reset_seq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == 8'h09 && i_wdata[7]) ##1 (i_wr && i_addr == 8'h09 && !i_wdata[7])
    |=> o_device_reset ##1 (o_ref_clock_enable == 1'b0)) else $error("soft reset not applied"); // [R1]
  a_acq_seq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == 8'h09 && i_wdata[6]) ##1 (i_wr && i_addr == 8'h09 && !i_wdata[6])
    |=> o_freq_acquire_trigger) else $error("acquisition not started"); // [R2]
  a_los_pol: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || o_device_reset)
    1'b1 |=> o_signal_loss_flag == $past(los_out)) else $error("signal loss pin wrong"); // [R4]
  a_signal_loss_powerdown: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !o_signal_loss_enable |=> o_signal_loss_flag == $past(reset_lock_control[2])) else $error("loss not gated"); // [R3]
  a_ref_enable: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || o_device_reset)
    (i_wr && i_addr == 8'h0A && !i_wdata[2]) |=> o_ref_clock_enable) else $error("ref clock not enabled"); // [R5]
  a_sticky_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (sticky_lol && !(i_wr && i_addr == 8'h08 && i_wdata[2])) |=> sticky_lol) else $error("sticky lost"); // [R16]
  a_sticky_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    lol_live |=> sticky_lol) else $error("event not caught"); // [R16]
  a_edge_both: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (o_edge_rise || o_edge_fall)
    && ((o_edge_rise && o_edge_fall) == (loop_edge_bandwidth[4] == loop_edge_bandwidth[3])))
    else $error("edge select wrong"); // [R9]
  a_bw_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || o_device_reset)
    (i_wr && i_addr == 8'h10) |=> o_transfer_bw_scale == $past(i_wdata[2:0])) else $error("bw not stored"); // [R10]
  a_lol_mode: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_cdr_bypass == reset_lock_control[5] && (o_lock_loss_flag == $past(lol_out))) else $error("lol output wrong"); // [R14]
  c_reset_seen: cover property (@(posedge i_core_clk) o_device_reset);
  c_acq_seen: cover property (@(posedge i_core_clk) o_freq_acquire_trigger);
  c_sticky_clear: cover property (@(posedge i_core_clk) sticky_lol ##1 !sticky_lol);
  c_ref_on: cover property (@(posedge i_core_clk) o_ref_clock_enable);
endmodule
`default_nettype wire

// ### cdrcr_host.sv
// Purpose: Management host model that writes and reads the control registers.
// Assumes: One-cycle write strobe and read data registered one cycle late.
// Notes: Requests change just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cdrcr_host (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // One write cycle; a one-then-zero pair on the reset or acquisition bit is two calls.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  // Two writes to one address on back-to-back cycles, the strobe held high between them.
  task automatic put2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge i_core_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d0;
    @(posedge i_core_clk);
    o_wdata <= d1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d1;
  endtask
  // Presents the address, then takes the registered data after the next edge.
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    @(posedge i_core_clk);
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the CDR control register bank.
// Assumes: The host model drives the management port.
// Notes: Random register traffic plus fixed corner cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ll_ref = 1'b0;
  logic ll_dat = 1'b0;
  logic los_raw = 1'b0;
  logic wr, dev_rst, acq, byp, los_en, los_flag, ref_en, lock_loss_flag, rise, fall, adapt;
  logic [7:0] addr, wdata, rdata, v, d, a;
  logic [1:0] band, slew;
  logic [3:0] ratio;
  logic [2:0] bw;
  logic [7:0] amap [6] = '{cdrcr_pkg::ADDR_RESET_LOCK, cdrcr_pkg::ADDR_REF_CLOCK, cdrcr_pkg::ADDR_REF_LOCK,
    cdrcr_pkg::ADDR_LOOP_EDGE, cdrcr_pkg::ADDR_SLICE_SLEW, 8'h20};
  int bad_count = 0;
  int tests_run = 0;
  int rst_cnt = 0;
  int acq_cnt = 0;
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    if (dev_rst === 1'b1) rst_cnt++;
    if (acq === 1'b1) acq_cnt++;
  end
  cdrcr_host i_host (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  cdrcr_bank i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .i_lock_loss_ref(ll_ref), .i_lock_loss_data(ll_dat), .i_signal_loss_raw(los_raw),
    .o_device_reset(dev_rst), .o_freq_acquire_trigger(acq), .o_cdr_bypass(byp), .o_signal_loss_enable(los_en),
    .o_signal_loss_flag(los_flag), .o_ref_clock_enable(ref_en), .o_lock_loss_flag(lock_loss_flag), .o_ref_freq_band(band),
    .o_rate_to_ref_divide(ratio), .o_edge_rise(rise), .o_edge_fall(fall), .o_transfer_bw_scale(bw),
    .o_adaptive_slice(adapt), .o_dll_slew(slew));
  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    i_host.get(ra, v);
    check(v, exp);
  endtask
  task automatic rd_resets;
    for (int i = 0; i < 6; i++) begin
      rd(amap[i], exp_reg(amap[i], 8'h00) | ((i == 1 || i == 3) ? 8'h04 : 8'h00));
    end
    check({7'h00, ref_en}, 8'h00);
  endtask
  function automatic logic [7:0] exp_reg(input logic [7:0] ea, input logic [7:0] ed);
    case (ea)
      cdrcr_pkg::ADDR_RESET_LOCK: return ed & cdrcr_pkg::MASK_RESET_LOCK;
      cdrcr_pkg::ADDR_REF_CLOCK: return (ed & cdrcr_pkg::MASK_REF_CLOCK) | 8'h01;
      cdrcr_pkg::ADDR_REF_LOCK: return ed & cdrcr_pkg::MASK_REF_LOCK;
      cdrcr_pkg::ADDR_LOOP_EDGE: return ed & cdrcr_pkg::MASK_LOOP_EDGE;
      cdrcr_pkg::ADDR_SLICE_SLEW: return ed & cdrcr_pkg::MASK_SLICE_SLEW;
      default: return 8'h00;
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(37));
    repeat (10) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd_resets();
    // Random traffic to each of the five control registers and an unmapped address, reserved bits written as the host must.
    for (int n = 0; n < 60; n++) begin
      a = amap[n % 6];
      d = 8'($urandom);
      d = exp_reg(a, d);
      if (a == cdrcr_pkg::ADDR_RESET_LOCK) d = d & 8'h3F;
      i_host.put(a, d);
      rd(a, exp_reg(a, d));
      if (a == cdrcr_pkg::ADDR_RESET_LOCK) check({6'h00, byp, los_en}, {6'h00, d[5], ~d[3]});
      if (a == cdrcr_pkg::ADDR_REF_CLOCK) check({7'h00, ref_en}, {7'h00, ~d[2]});
      if (a == cdrcr_pkg::ADDR_REF_LOCK) check({2'h0, band, ratio}, {2'h0, d[5:0]});
      if (a == cdrcr_pkg::ADDR_LOOP_EDGE) check({3'h0, rise, fall, bw}, {3'h0, d[4:3] != 2'h2, d[4:3] != 2'h1, d[2:0]});
      if (a == cdrcr_pkg::ADDR_SLICE_SLEW) check({5'h00, adapt, slew}, {5'h00, d[2:0]});
    end
    i_host.put(cdrcr_pkg::ADDR_REF_LOCK, 8'h00);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'h00);
    los_raw <= 1'b1;
    ll_ref <= 1'b1;
    idle(2);
    check({6'h00, los_flag, lock_loss_flag}, 8'h03);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'h04);
    idle(2);
    check({7'h00, los_flag}, 8'h00);
    i_host.put(cdrcr_pkg::ADDR_REF_LOCK, 8'h40);
    idle(2);
    check({7'h00, lock_loss_flag}, 8'h00);
    @(posedge i_core_clk);
    ll_dat <= 1'b1;
    los_raw <= 1'b0;
    idle(2);
    check({6'h00, los_flag, lock_loss_flag}, 8'h03);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'h10);
    ll_dat <= 1'b0;
    idle(3);
    check({7'h00, lock_loss_flag}, 8'h01);
    i_host.get(cdrcr_pkg::ADDR_STATUS, v);
    check(v & 8'h04, 8'h04);
    i_host.put(cdrcr_pkg::ADDR_MAIN_CTRL, 8'h04);
    idle(2);
    check({7'h00, lock_loss_flag}, 8'h00);
    i_host.get(cdrcr_pkg::ADDR_STATUS, v);
    check(v & 8'h04, 8'h00);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'h40);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'h00);
    idle(3);
    check(8'(acq_cnt), 8'h01);
    i_host.put2(cdrcr_pkg::ADDR_RESET_LOCK, 8'h40, 8'h00);
    idle(3);
    check(8'(acq_cnt), 8'h02);
    i_host.put(cdrcr_pkg::ADDR_LOOP_EDGE, 8'h1B);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'hA0);
    i_host.put(cdrcr_pkg::ADDR_RESET_LOCK, 8'h20);
    idle(3);
    check({8'(rst_cnt)}, 8'h01);
    check(8'(acq_cnt), 8'h02);
    rd_resets();
    i_host.put(cdrcr_pkg::ADDR_LOOP_EDGE, 8'h1B);
    i_host.put2(cdrcr_pkg::ADDR_RESET_LOCK, 8'h80, 8'h00);
    idle(3);
    check(8'(rst_cnt), 8'h02);
    rd(cdrcr_pkg::ADDR_LOOP_EDGE, cdrcr_pkg::RST_LOOP_EDGE);
    summarize();
  end
endmodule
`default_nettype wire
